/* File: verilog/bas_sequencer.sv */
// burst address sequencer with AXI4-Lite configuration registers
// assumes the host holds burst requests away from die boundaries and ends bursts with chip select
`timescale 1ns/1ps

// How it works
// - legacy wrapped bursts never leave their aligned group
// - group sizes 16, 32, 64 and 128 bytes, aligned to size
// - wrap starts at given address, runs to group end, rolls to group start
// - hybrid wraps once, then continues at start of next group
// - hybrid then runs linear until chip select goes high
// - hybrid-enable bit: zero hybrid, one legacy wrap (reset default)
// - each beat moves one word, byte address plus two
// - burst type bit: one linear (default), zero wrapped
// - hybrid selection counts only when command burst type bit is zero
// - length field: 00=128, 01=64, 10=16, 11=32 (default)
module bas_sequencer #(
  parameter int ADDR_W = bas_pkg::BAS_ADDR_W
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // burst control
  input  wire bas_pkg::bas_cmd_t           cmd,
  input  wire logic                        beat,
  input  wire logic                        chipSelectN,
  // sequenced address
  output logic      [ADDR_W-1:0]           beatAddr,
  output logic                             burstActive,
  // AXI4-Lite write
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import bas_pkg::*;

  // command address is fixed at the package width
  if (ADDR_W != BAS_ADDR_W) begin : g_badAddrW
    $error("ADDR_W must equal the command address width");
  end

  // chip select synchroniser, three stages
  logic [2:0] csSync_reg, csSync_next;
  logic       csHigh_reg, csHigh_next;

  // configuration
  logic [15:0] burstCfg_reg, burstCfg_next;
  logic [15:0] refreshCfg_reg, refreshCfg_next;

  // sequencer state
  bas_state_t        state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              hybrid_reg, hybrid_next;
  logic [7:0]        mask_reg, mask_next;
  logic              active_reg, active_next;

  // bus slave state
  logic        awHeld_reg, awHeld_next;
  logic [7:0]  awAddr_reg, awAddr_next;
  logic        wHeld_reg, wHeld_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next;
  logic [1:0]  bResp_reg, bResp_next;
  logic        arRdy_reg, arRdy_next;
  logic        awRdy_reg, awRdy_next;
  logic        wRdy_reg, wRdy_next;
  logic        rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0]  rResp_reg, rResp_next;

  logic [ADDR_W-1:0] stepAddr;
  logic              stepLast;
  logic [7:0]        cmdMask;
  logic              cmdWrap;
  logic              cmdHybrid;

  // wrap is complete when the next beat would return to the starting word
  logic [7:0] startLow_reg, startLow_next;
  function automatic logic wrapDone(input logic [ADDR_W-1:0] nxt, input logic [7:0] msk, input logic [7:0] st);
    return (nxt[7:0] & msk) == (st & msk);
  endfunction

  function automatic logic [7:0] lenMask(input logic [1:0] code);
    logic [7:0] m;
    m = 8'h1f;
    case (code)
      BAS_LEN_128: m = 8'h7f;
      BAS_LEN_64:  m = 8'h3f;
      BAS_LEN_16:  m = 8'h0f;
      BAS_LEN_32:  m = 8'h1f;
      default:     m = 8'h1f;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  bas_addr_step #(
    .ADDR_W(ADDR_W)
  ) u_step (
    .addr        (addr_reg),
    .groupMask   (mask_reg),
    .wrapOn      (state_reg == BAS_WRAP),
    .nextAddr    (stepAddr),
    .lastInGroup (stepLast)
  );

  // chip select filter
  always_comb begin
    csSync_next = {csSync_reg[1:0], chipSelectN};
    csHigh_next = csHigh_reg;
    if (csSync_reg[1] == csSync_reg[2]) begin
      csHigh_next = csSync_reg[2];
    end
  end

  // burst sequencing
  always_comb begin
    cmdWrap     = refreshCfg_reg[BAS_TYPE_BIT] == 1'b0 && cmd.wrapType == 1'b0;
    cmdHybrid   = ~burstCfg_reg[BAS_HYBRID_BIT] & ~cmd.wrapType;
    cmdMask     = lenMask(burstCfg_reg[BAS_LEN_LSB +: 2]);
    state_next  = state_reg;
    addr_next   = addr_reg;
    hybrid_next = hybrid_reg;
    mask_next   = mask_reg;
    active_next = active_reg;
    if (cmd.start) begin
      addr_next   = {cmd.addr[ADDR_W-1:1], 1'b0};
      mask_next   = cmdMask;
      hybrid_next = cmdHybrid;
      state_next  = cmdWrap ? BAS_WRAP : BAS_LINEAR;
      active_next = 1'b1;
    end else if (csHigh_reg) begin
      state_next  = BAS_IDLE;
      active_next = 1'b0;
    end else if (beat && state_reg != BAS_IDLE) begin
      addr_next = stepAddr;
      if (state_reg == BAS_WRAP && hybrid_reg && wrapDone(stepAddr, mask_reg, startLow_reg)) begin
        addr_next  = (addr_reg | ADDR_W'(mask_reg)) + ADDR_W'(1);
        state_next = BAS_LINEAR;
      end
    end
  end

  always_comb begin
    startLow_next = cmd.start ? {cmd.addr[7:1], 1'b0} : startLow_reg;
  end

  // AXI4-Lite slave
  logic doWrite;
  logic wrOk;
  always_comb begin
    awHeld_next     = awHeld_reg;
    awAddr_next     = awAddr_reg;
    wHeld_next      = wHeld_reg;
    wData_next      = wData_reg;
    wStrb_next      = wStrb_reg;
    bValid_next     = bValid_reg;
    bResp_next      = bResp_reg;
    burstCfg_next   = burstCfg_reg;
    refreshCfg_next = refreshCfg_reg;
    if (s_axi_awvalid && awRdy_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wRdy_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
    wrOk    = 1'b0;
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      if (awAddr_reg == BAS_BURST_CFG_OFF) begin
        burstCfg_next = mergeLow(burstCfg_reg, wData_reg, wStrb_reg);
        wrOk = 1'b1;
      end else if (awAddr_reg == BAS_REFRESH_CFG_OFF) begin
        refreshCfg_next = mergeLow(refreshCfg_reg, wData_reg, wStrb_reg);
        refreshCfg_next[1:0] = refreshCfg_reg[1:0];
        wrOk = 1'b1;
      end else if (awAddr_reg == BAS_STATUS_OFF || awAddr_reg == BAS_ID_OFF) begin
        wrOk = 1'b1;
      end
      bResp_next = wrOk ? 2'b00 : 2'b10;
    end else if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    awRdy_next = !awHeld_next;
    wRdy_next  = !wHeld_next;
  end

  always_comb begin
    arRdy_next  = arRdy_reg;
    rValid_next = rValid_reg;
    rData_next  = rData_reg;
    rResp_next  = rResp_reg;
    if (s_axi_arvalid && arRdy_reg) begin
      arRdy_next  = 1'b0;
      rValid_next = 1'b1;
      rResp_next  = 2'b00;
      if (s_axi_araddr == BAS_BURST_CFG_OFF) begin
        rData_next = {16'h0000, burstCfg_reg};
      end else if (s_axi_araddr == BAS_REFRESH_CFG_OFF) begin
        rData_next = {16'h0000, refreshCfg_reg};
      end else if (s_axi_araddr == BAS_STATUS_OFF) begin
        rData_next = 32'({active_reg, state_reg, 5'h00, addr_reg});
      end else if (s_axi_araddr == BAS_ID_OFF) begin
        rData_next = BAS_ID_VALUE;
      end else begin
        rData_next = 32'h0000_0000;
        rResp_next = 2'b10;
      end
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
      arRdy_next  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      csSync_reg     <= 3'h7;
      csHigh_reg     <= 1'b1;
      burstCfg_reg   <= BAS_BURST_CFG_RST;
      refreshCfg_reg <= BAS_REFRESH_CFG_RST;
      state_reg      <= BAS_IDLE;
      addr_reg       <= '0;
      hybrid_reg     <= 1'b0;
      mask_reg       <= 8'h1f;
      active_reg     <= 1'b0;
      startLow_reg   <= 8'h00;
      awHeld_reg     <= 1'b0;
      awAddr_reg     <= 8'h00;
      wHeld_reg      <= 1'b0;
      wData_reg      <= 32'h0000_0000;
      wStrb_reg      <= 4'h0;
      bValid_reg     <= 1'b0;
      bResp_reg      <= 2'b00;
      awRdy_reg      <= 1'b0;
      wRdy_reg       <= 1'b0;
      arRdy_reg      <= 1'b0;
      rValid_reg     <= 1'b0;
      rData_reg      <= 32'h0000_0000;
      rResp_reg      <= 2'b00;
    end else begin
      csSync_reg     <= csSync_next;
      csHigh_reg     <= csHigh_next;
      burstCfg_reg   <= burstCfg_next;
      refreshCfg_reg <= refreshCfg_next;
      state_reg      <= state_next;
      addr_reg       <= addr_next;
      hybrid_reg     <= hybrid_next;
      mask_reg       <= mask_next;
      active_reg     <= active_next;
      startLow_reg   <= startLow_next;
      awHeld_reg     <= awHeld_next;
      awAddr_reg     <= awAddr_next;
      wHeld_reg      <= wHeld_next;
      wData_reg      <= wData_next;
      wStrb_reg      <= wStrb_next;
      bValid_reg     <= bValid_next;
      bResp_reg      <= bResp_next;
      awRdy_reg      <= awRdy_next;
      wRdy_reg       <= wRdy_next;
      arRdy_reg      <= (rValid_reg || rValid_next) ? arRdy_next : 1'b1;
      rValid_reg     <= rValid_next;
      rData_reg      <= rData_next;
      rResp_reg      <= rResp_next;
    end
  end

  assign beatAddr      = addr_reg;
  assign burstActive   = active_reg;
  assign s_axi_awready = awRdy_reg;
  assign s_axi_wready  = wRdy_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = arRdy_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  // wrap beats keep upper address bits
  property p_wrapHoldsGroup;
    @(posedge clk) disable iff (!resetn)
      (state_reg == BAS_WRAP && $past(state_reg) == BAS_WRAP && !$past(cmd.start))
        |-> ((addr_reg & ~ADDR_W'(mask_reg)) == ($past(addr_reg) & ~ADDR_W'(mask_reg)));
  endproperty
  a_wrapHoldsGroup: assert property (p_wrapHoldsGroup) else $error("wrap left its group");

  property p_stepTwo;
    @(posedge clk) disable iff (!resetn)
      (state_reg == BAS_LINEAR && beat && !cmd.start && !csHigh_reg && $past(state_reg) == BAS_LINEAR)
        |=> (addr_reg == $past(addr_reg) + ADDR_W'(BAS_BEAT_BYTES));
  endproperty
  a_stepTwo: assert property (p_stepTwo) else $error("linear beat did not add two");

  property p_startAddr;
    @(posedge clk) disable iff (!resetn)
      cmd.start |=> (addr_reg == {$past(cmd.addr[ADDR_W-1:1]), 1'b0}) && active_reg;
  endproperty
  a_startAddr: assert property (p_startAddr) else $error("burst did not start at command address");

  // last word of a group always rolls to a group start, in wrap or in hybrid jump
  property p_rollOver;
    @(posedge clk) disable iff (!resetn)
      (state_reg == BAS_WRAP && beat && stepLast && !cmd.start && !csHigh_reg)
        |=> ((addr_reg & ADDR_W'(mask_reg)) == '0);
  endproperty
  a_rollOver: assert property (p_rollOver) else $error("group end did not roll to group start");

  property p_typeSelect;
    @(posedge clk) disable iff (!resetn)
      (cmd.start && refreshCfg_reg[BAS_TYPE_BIT]) |=> state_reg == BAS_LINEAR;
  endproperty
  a_typeSelect: assert property (p_typeSelect) else $error("linear type bit ignored");

  property p_hybridIgnored;
    @(posedge clk) disable iff (!resetn)
      (cmd.start && cmd.wrapType) |=> !hybrid_reg;
  endproperty
  a_hybridIgnored: assert property (p_hybridIgnored) else $error("hybrid taken with linear command");

  property p_legacyStays;
    @(posedge clk) disable iff (!resetn)
      (state_reg == BAS_WRAP && !hybrid_reg && !cmd.start && !csHigh_reg) |=> state_reg == BAS_WRAP;
  endproperty
  a_legacyStays: assert property (p_legacyStays) else $error("legacy wrap left wrapping");

  property p_hybridNextGroup;
    @(posedge clk) disable iff (!resetn)
      (state_reg == BAS_LINEAR && $past(state_reg) == BAS_WRAP && !$past(cmd.start) && !$past(csHigh_reg))
        |-> ((addr_reg & ADDR_W'(mask_reg)) == '0);
  endproperty
  a_hybridNextGroup: assert property (p_hybridNextGroup) else $error("hybrid not at next group start");

  property p_csEnds;
    @(posedge clk) disable iff (!resetn)
      (csHigh_reg && !cmd.start) |=> !active_reg && state_reg == BAS_IDLE;
  endproperty
  a_csEnds: assert property (p_csEnds) else $error("burst survived chip select high");

  property p_lenCode;
    @(posedge clk) disable iff (!resetn)
      cmd.start |=> mask_reg == ($past(burstCfg_reg[1:0]) == 2'h0 ? 8'h7f :
                                 $past(burstCfg_reg[1:0]) == 2'h1 ? 8'h3f :
                                 $past(burstCfg_reg[1:0]) == 2'h2 ? 8'h0f : 8'h1f);
  endproperty
  a_lenCode: assert property (p_lenCode) else $error("group length code wrong");

endmodule

/* File: verilog/bas_pkg.sv */
// package for the burst address sequencer: register map, field layout, reset values, types
// assumes an AXI4-Lite master on the same 40 MHz clock
package bas_pkg;

  // register byte offsets
  localparam logic [7:0] BAS_BURST_CFG_OFF   = 8'h00;  // burst_config_register
  localparam logic [7:0] BAS_REFRESH_CFG_OFF = 8'h04;  // refresh_burst_config_register
  localparam logic [7:0] BAS_STATUS_OFF      = 8'h08;  // current address and state
  localparam logic [7:0] BAS_ID_OFF          = 8'h0c;  // identity word

  // burst_config_register fields
  localparam int BAS_LEN_LSB    = 0;
  localparam int BAS_HYBRID_BIT = 2;
  localparam logic [15:0] BAS_BURST_CFG_RST = 16'h8f2f;
  // refresh_burst_config_register fields
  localparam int BAS_TYPE_BIT = 7;
  localparam logic [15:0] BAS_REFRESH_CFG_RST = 16'hffc1;

  // identity value is arbitrary
  localparam logic [31:0] BAS_ID_VALUE = 32'h0000_5a5a;

  // group length encodings
  localparam logic [1:0] BAS_LEN_128 = 2'h0;
  localparam logic [1:0] BAS_LEN_64  = 2'h1;
  localparam logic [1:0] BAS_LEN_16  = 2'h2;
  localparam logic [1:0] BAS_LEN_32  = 2'h3;

  // byte step per beat: one 16-bit word
  localparam int BAS_BEAT_BYTES = 2;

  localparam int BAS_ADDR_W = 24;

  typedef enum logic [1:0] {
    BAS_IDLE   = 2'b00,
    BAS_WRAP   = 2'b01,
    BAS_LINEAR = 2'b11
  } bas_state_t;

  // command/address phase as seen by the sequencer
  typedef struct packed {
    logic                  start;
    logic                  wrapType;    // 0 selects wrapped (command_address_phase burst type)
    logic [BAS_ADDR_W-1:0] addr;        // byte address
  } bas_cmd_t;

endpackage

/* File: verilog/bas_addr_step.sv */
// next-address arithmetic for one burst beat
// assumes byte addresses on word boundaries; pure combinational
`timescale 1ns/1ps
module bas_addr_step #(
  parameter int ADDR_W = 24
) (
  // current beat
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        groupMask,
  input  wire logic              wrapOn,
  // next beat
  output logic      [ADDR_W-1:0] nextAddr,
  output logic                   lastInGroup
);
  import bas_pkg::*;

  logic [ADDR_W-1:0] linAddr;
  logic [7:0]        lowInc;

  always_comb begin
    linAddr     = addr + ADDR_W'(BAS_BEAT_BYTES);
    lowInc      = addr[7:0] + 8'(BAS_BEAT_BYTES);
    lastInGroup = ((addr[7:0] & groupMask) == (groupMask & 8'hfe));
    if (wrapOn) begin
      // only low bits move, upper bits held
      nextAddr = {addr[ADDR_W-1:8], (addr[7:0] & ~groupMask) | (lowInc & groupMask)};
    end else begin
      nextAddr = linAddr;
    end
  end

endmodule

/* File: test/bas_host_model.sv */
// host memory controller model: chip select, command phase and beat strobes
// assumes one clock shared with the sequencer; the bench calls the tasks
`timescale 1ns/1ps
module bas_host_model (
  // clock
  input  wire logic          clk,
  // burst control towards the sequencer
  output bas_pkg::bas_cmd_t  cmd,
  output logic               beat,
  output logic               chipSelectN
);
  import bas_pkg::*;

  initial begin
    cmd         = '0;
    beat        = 1'b0;
    chipSelectN = 1'b1;
  end

  // select, let the pin synchroniser settle, then one start pulse
  task automatic openBurst(input logic [BAS_ADDR_W-1:0] a, input logic wt);
    @(posedge clk);
    chipSelectN <= 1'b0;
    repeat (5) @(posedge clk);
    cmd <= '{start: 1'b1, wrapType: wt, addr: a};  // callers keep each group inside one die
    @(posedge clk);
    cmd <= '{start: 1'b0, wrapType: ~wt, addr: ~a};  // released lines carry no stale value
  endtask

  // one word transferred
  task automatic step();
    @(posedge clk);
    beat <= 1'b1;
    @(posedge clk);
    beat <= 1'b0;
  endtask

  task automatic closeBurst();
    chipSelectN <= 1'b1;  // host ends the burst
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the burst address sequencer
// assumes the host model drives the burst side and the bench is the AXI4-Lite master
`timescale 1ns/1ps
module testbench;
  import bas_pkg::*;

  logic              clk;
  logic              resetn;
  bas_cmd_t          cmd;
  logic              beat;
  logic              chipSelectN;
  logic [23:0]       beatAddr;
  logic              burstActive;
  logic [7:0]        s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [7:0]        s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  int                nMismatch = 0;
  int                checksDone = 0;
  int                lenBytes [4] = '{128, 64, 16, 32};

  bas_sequencer bas_sequencer_i (.clk(clk), .resetn(resetn), .cmd(cmd), .beat(beat), .chipSelectN(chipSelectN),
    .beatAddr(beatAddr), .burstActive(burstActive), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  bas_host_model bas_host_model_i (.clk(clk), .cmd(cmd), .beat(beat), .chipSelectN(chipSelectN));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic printVerdict();
    $display("mismatches %0d checks %0d", nMismatch, checksDone);
    if (nMismatch == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= dat;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // m: 0 linear, 1 legacy wrap, 2 hybrid; g: group bytes
  function automatic logic [23:0] nextAddr(input logic [23:0] c, input logic [23:0] s, input int m, input int g,
                                           inout logic done);
    logic [23:0] msk;
    logic [23:0] w;
    msk = 24'(g - 1);
    w   = (c & ~msk) | ((c + 24'h2) & msk);
    if (m == 0 || done)
      return c + 24'h2;
    if (m == 2 && w == s) begin
      done = 1'b1;
      return (c & ~msk) + 24'(g);
    end
    return w;
  endfunction

  task automatic runBurst(input logic [23:0] a, input logic wt, input int m, input int g, input int n);
    logic [23:0] e;
    logic        done;
    logic [31:0] d;
    logic [1:0]  r;
    bas_state_t  st;
    e    = a;
    done = 1'b0;
    bas_host_model_i.openBurst(a, wt);
    #1 check("start address", {8'h0, e}, {8'h0, beatAddr});
    for (int k = 0; k < n; k++) begin
      bas_host_model_i.step();
      e = nextAddr(e, a, m, g, done);
      #1 check("beat address", {8'h0, e}, {8'h0, beatAddr});
    end
    st = (m == 0 || done) ? BAS_LINEAR : BAS_WRAP;
    axiRead(BAS_STATUS_OFF, d, r);
    check("status", {1'b1, st, 5'h0, e}, d);
    bas_host_model_i.closeBurst();
    repeat (8) @(posedge clk);
    #1 check("burst active", 32'h0, {31'h0, burstActive});
    bas_host_model_i.step();
    #1 check("idle beat", {8'h0, e}, {8'h0, beatAddr});
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    resetn        = 1'b0;
    s_axi_awaddr  = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    axiRead(BAS_BURST_CFG_OFF, d, r);
    check("burst cfg reset", {16'h0, BAS_BURST_CFG_RST}, d);
    axiRead(BAS_REFRESH_CFG_OFF, d, r);
    check("refresh cfg reset", {16'h0, BAS_REFRESH_CFG_RST}, d);
    axiRead(BAS_ID_OFF, d, r);
    check("id", BAS_ID_VALUE, d);
    axiRead(BAS_STATUS_OFF, d, r);
    check("idle status", 32'h0, d);
    axiRead(8'h10, d, r);
    check("unmapped read resp", 32'h2, {30'h0, r});
    check("unmapped read data", 32'h0, d);
    axiWrite(8'h10, 32'hffff_ffff, r);
    check("unmapped write resp", 32'h2, {30'h0, r});
    runBurst(24'h123402, 1'b0, 0, 32, 17);
    axiWrite(BAS_REFRESH_CFG_OFF, 32'h0000ff40, r);
    axiRead(BAS_REFRESH_CFG_OFF, d, r);
    check("refresh cfg wrapped", 32'h0000ff41, d);
    runBurst(24'h12341a, 1'b0, 1, 32, 20);
    for (int h = 1; h >= 0; h--) begin
      for (int l = 0; l < 4; l++) begin
        axiWrite(BAS_BURST_CFG_OFF, 32'h00008f28 | 32'(h << 2) | 32'(l), r);
        check("cfg write resp", 32'h0, {30'h0, r});
        runBurst(24'h123400 + 24'(lenBytes[l] - 4), 1'b0, h ? 1 : 2, lenBytes[l], lenBytes[l] / 2 + 4);
      end
    end
    runBurst(24'h123406, 1'b1, 0, 32, 20);
    axiWrite(BAS_REFRESH_CFG_OFF, 32'h0000ffc1, r);
    runBurst(24'h123406, 1'b0, 0, 32, 20);
    printVerdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    $display("watchdog expired");
    printVerdict();
  end
endmodule
